// ### src/tpc_defs.vh
// constants for the timer pair and input capture block
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH

// register byte offsets on the wishbone bus
`define TPC_OFS_LO_CTL 8'h00
`define TPC_OFS_HI_CTL 8'h04
`define TPC_OFS_LO_CNT 8'h08
`define TPC_OFS_HI_CNT 8'h0c
`define TPC_OFS_CH_BASE 8'h10
`define TPC_OFS_CH_STEP 8'h08
`define TPC_OFS_CH_BUF 8'h04

// timer control fields
`define TPC_T_RUN 15
`define TPC_T_IDLE_STOP 13
`define TPC_T_GATE 6
`define TPC_T_PS_HI 5
`define TPC_T_PS_LO 4
`define TPC_T_JOIN 3
`define TPC_T_CS 1
`define TPC_LO_CTL_WMASK 16'ha07a
`define TPC_HI_CTL_WMASK 16'ha072
`define TPC_CTL_RESET 16'h0000
`define TPC_CNT_RESET 16'h0000

// prescale terminal counts for 1:1, 1:8, 1:64, 1:256
`define TPC_PS_LIM_1 8'h00
`define TPC_PS_LIM_8 8'h07
`define TPC_PS_LIM_64 8'h3f
`define TPC_PS_LIM_256 8'hff

// capture control fields
`define TPC_C_IDLE_STOP 13
`define TPC_C_TB_SEL 7
`define TPC_C_IRQ_HI 6
`define TPC_C_IRQ_LO 5
`define TPC_C_OVF 4
`define TPC_C_NE 3
`define TPC_C_MODE_HI 2
`define TPC_C_WMASK 16'h20e7

// capture modes
`define TPC_M_OFF 3'h0
`define TPC_M_EVERY 3'h1
`define TPC_M_FALL 3'h2
`define TPC_M_RISE 3'h3
`define TPC_M_RISE4 3'h4
`define TPC_M_RISE16 3'h5
`define TPC_M_UNUSED 3'h6
`define TPC_M_WAKE 3'h7

// fifo depth and rising-edge prescale terminal counts
`define TPC_FIFO_DEPTH 4
`define TPC_DIV4_LIM 4'h3
`define TPC_DIV16_LIM 4'hf

`endif

// ### src/tpc_top.v
// timer pair with 16/32-bit operation and input capture channels on wishbone
`include "tpc_defs.vh"

module tpc_top #(
  parameter NCH = 2
) (
  input wire sys_clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire cpu_idle,
  input wire cpu_sleep,
  input wire [1:0] external_counter_clock_pin,
  input wire [NCH-1:0] capture_pin,
  output reg lo_wrap_irq,
  output reg hi_wrap_irq,
  output reg [NCH-1:0] capture_irq,
  output reg wake_req
);

  function [7:0] ps_lim;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: ps_lim = `TPC_PS_LIM_1;
        2'h1: ps_lim = `TPC_PS_LIM_8;
        2'h2: ps_lim = `TPC_PS_LIM_64;
        default: ps_lim = `TPC_PS_LIM_256;
      endcase
    end
  endfunction

  // bus handshake: one wait state, ack for one cycle
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire [15:0] wmask16 = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // pin synchronisers; stage 3 only feeds the edge detectors
  reg [1:0] tck_s1_reg, tck_s2_reg, tck_s3_reg;
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      tck_s1_reg <= 2'h0;
      tck_s2_reg <= 2'h0;
      tck_s3_reg <= 2'h0;
    end
    else
    begin
      tck_s1_reg <= external_counter_clock_pin;
      tck_s2_reg <= tck_s1_reg;
      tck_s3_reg <= tck_s2_reg;
    end
  end
  wire [1:0] tck_rise = tck_s2_reg & ~tck_s3_reg;

  reg [15:0] lo_ctl_reg, hi_ctl_reg, lo_cnt_reg, hi_cnt_reg;
  reg [7:0] lo_ps_reg, hi_ps_reg;

  wire join_en = lo_ctl_reg[`TPC_T_JOIN];
  wire lo_sel_ext = lo_ctl_reg[`TPC_T_CS];
  wire hi_sel_ext = hi_ctl_reg[`TPC_T_CS];
  // gated accumulation counts while the timer's pin is high
  wire lo_src = lo_sel_ext ? tck_rise[0] :
                (lo_ctl_reg[`TPC_T_GATE] ? tck_s2_reg[0] : 1'b1);
  wire hi_src = hi_sel_ext ? tck_rise[1] :
                (hi_ctl_reg[`TPC_T_GATE] ? tck_s2_reg[1] : 1'b1);
  // joined pair honours either idle-stop bit, the upper one stays meaningful
  wire lo_idle_halt = cpu_idle & (lo_ctl_reg[`TPC_T_IDLE_STOP] |
                      (join_en & hi_ctl_reg[`TPC_T_IDLE_STOP]));
  wire hi_idle_halt = cpu_idle & hi_ctl_reg[`TPC_T_IDLE_STOP];
  wire lo_go = lo_ctl_reg[`TPC_T_RUN] & ~lo_idle_halt & lo_src;
  wire hi_go = hi_ctl_reg[`TPC_T_RUN] & ~join_en & ~hi_idle_halt & hi_src;
  wire lo_tick = lo_go & (lo_ps_reg == ps_lim(lo_ctl_reg[5:4]));
  wire hi_tick_own = hi_go & (hi_ps_reg == ps_lim(hi_ctl_reg[5:4]));
  wire lo_carry = lo_tick & (lo_cnt_reg == 16'hffff);
  wire hi_tick = join_en ? lo_carry : hi_tick_own;

  wire wr_lo_ctl = wr & (wb_adr_i == `TPC_OFS_LO_CTL);
  wire wr_hi_ctl = wr & (wb_adr_i == `TPC_OFS_HI_CTL);
  wire wr_lo_cnt = wr & (wb_adr_i == `TPC_OFS_LO_CNT);
  wire wr_hi_cnt = wr & (wb_adr_i == `TPC_OFS_HI_CNT);
  wire [15:0] lo_wm = wmask16 & `TPC_LO_CTL_WMASK;
  wire [15:0] hi_wm = wmask16 & `TPC_HI_CTL_WMASK;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      lo_ctl_reg <= `TPC_CTL_RESET;
      hi_ctl_reg <= `TPC_CTL_RESET;
      lo_cnt_reg <= `TPC_CNT_RESET;
      hi_cnt_reg <= `TPC_CNT_RESET;
      lo_ps_reg <= 8'h00;
      hi_ps_reg <= 8'h00;
      lo_wrap_irq <= 1'b0;
      hi_wrap_irq <= 1'b0;
    end
    else
    begin
      if (wr_lo_ctl)
        lo_ctl_reg <= (lo_ctl_reg & ~lo_wm) | (wb_dat_i[15:0] & lo_wm);
      if (wr_hi_ctl)
        hi_ctl_reg <= (hi_ctl_reg & ~hi_wm) | (wb_dat_i[15:0] & hi_wm);
      // prescaler restarts whenever its run bit is clear
      if (!lo_ctl_reg[`TPC_T_RUN])
        lo_ps_reg <= 8'h00;
      else if (lo_tick)
        lo_ps_reg <= 8'h00;
      else if (lo_go)
        lo_ps_reg <= lo_ps_reg + 8'h01;
      if (!hi_ctl_reg[`TPC_T_RUN] || join_en)
        hi_ps_reg <= 8'h00;
      else if (hi_tick_own)
        hi_ps_reg <= 8'h00;
      else if (hi_go)
        hi_ps_reg <= hi_ps_reg + 8'h01;
      // a software write wins over a count in the same cycle
      if (wr_lo_cnt)
        lo_cnt_reg <= (lo_cnt_reg & ~wmask16) | (wb_dat_i[15:0] & wmask16);
      else if (lo_tick)
        lo_cnt_reg <= lo_cnt_reg + 16'h0001;
      if (wr_hi_cnt)
        hi_cnt_reg <= (hi_cnt_reg & ~wmask16) | (wb_dat_i[15:0] & wmask16);
      else if (hi_tick)
        hi_cnt_reg <= hi_cnt_reg + 16'h0001;
      lo_wrap_irq <= lo_carry & ~join_en;
      hi_wrap_irq <= hi_tick & (hi_cnt_reg == 16'hffff);
    end
  end

  // capture channels
  wire [NCH*16-1:0] ch_ctl_flat;
  wire [NCH*16-1:0] ch_head_flat;
  wire [NCH-1:0] ch_wake;
  wire [NCH-1:0] ch_irq;

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1)
    begin : g_ch
      localparam [31:0] CTL_OFS_W = `TPC_OFS_CH_BASE + i * `TPC_OFS_CH_STEP;
      localparam [7:0] CTL_OFS = CTL_OFS_W[7:0];
      localparam [7:0] BUF_OFS = CTL_OFS + `TPC_OFS_CH_BUF;
      reg s1_reg, s2_reg, s3_reg;
      reg [15:0] ctl_reg;
      reg [15:0] mem_reg [0:`TPC_FIFO_DEPTH-1];
      reg [1:0] wp_reg, rp_reg;
      reg [2:0] cnt_reg;
      reg ovf_reg;
      reg [3:0] div_reg;
      reg [1:0] irq_cnt_reg;
      reg irq_reg, wake_reg;

      wire [2:0] mode = ctl_reg[`TPC_C_MODE_HI:0];
      wire rise = s2_reg & ~s3_reg;
      wire fall = ~s2_reg & s3_reg;
      wire low_power = cpu_idle | cpu_sleep;
      wire halted = cpu_idle & ctl_reg[`TPC_C_IDLE_STOP];
      wire wr_ctl = wr & (wb_adr_i == CTL_OFS);
      wire [15:0] wm = wmask16 & `TPC_C_WMASK;
      wire full = (cnt_reg == `TPC_FIFO_DEPTH);
      wire not_empty = (cnt_reg != 3'h0);
      wire pop = rd & (wb_adr_i == BUF_OFS) & not_empty;
      reg event_hit;

      always @*
      begin
        event_hit = 1'b0;
        case (mode)
          `TPC_M_EVERY: event_hit = rise | fall;
          `TPC_M_FALL: event_hit = fall;
          `TPC_M_RISE: event_hit = rise;
          `TPC_M_RISE4: event_hit = rise & (div_reg[1:0] == `TPC_DIV4_LIM);
          `TPC_M_RISE16: event_hit = rise & (div_reg == `TPC_DIV16_LIM);
          default: event_hit = 1'b0;
        endcase
      end
      wire cap = event_hit & ~halted;
      wire [15:0] tb = ctl_reg[`TPC_C_TB_SEL] ? lo_cnt_reg : hi_cnt_reg;
      wire push = cap & ~full;
      // mode 001 ignores the count field and interrupts on every capture
      wire [1:0] irq_lim = (mode == `TPC_M_EVERY) ? 2'h0 :
                           ctl_reg[`TPC_C_IRQ_HI:`TPC_C_IRQ_LO];
      wire wake_edge = (mode == `TPC_M_WAKE) & rise & low_power;

      always @(posedge sys_clk)
      begin
        if (rst)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          ctl_reg <= `TPC_CTL_RESET;
          wp_reg <= 2'h0;
          rp_reg <= 2'h0;
          cnt_reg <= 3'h0;
          ovf_reg <= 1'b0;
          div_reg <= 4'h0;
          irq_cnt_reg <= 2'h0;
          irq_reg <= 1'b0;
          wake_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= capture_pin[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (wr_ctl)
            ctl_reg <= (ctl_reg & ~wm) | (wb_dat_i[15:0] & wm);
          // a control write restarts edge and interrupt counting
          if (wr_ctl)
            div_reg <= 4'h0;
          else if (rise && !halted && (mode == `TPC_M_RISE4 || mode == `TPC_M_RISE16))
            div_reg <= event_hit ? 4'h0 : div_reg + 4'h1;
          if (push)
            wp_reg <= wp_reg + 2'h1;
          if (pop)
            rp_reg <= rp_reg + 2'h1;
          if (push && !pop)
            cnt_reg <= cnt_reg + 3'h1;
          else if (pop && !push)
            cnt_reg <= cnt_reg - 3'h1;
          // a lost capture sets overflow; a pop clears it, the set wins
          if (cap && full)
            ovf_reg <= 1'b1;
          else if (pop || mode == `TPC_M_OFF)
            ovf_reg <= 1'b0;
          if (wr_ctl)
            irq_cnt_reg <= 2'h0;
          else if (push)
            irq_cnt_reg <= (irq_cnt_reg == irq_lim) ? 2'h0 : irq_cnt_reg + 2'h1;
          irq_reg <= (push && irq_cnt_reg == irq_lim) || wake_edge;
          wake_reg <= (cap & low_power) | wake_edge;
        end
      end

      always @(posedge sys_clk)
      begin
        if (push)
          mem_reg[wp_reg] <= tb;
      end

      assign ch_ctl_flat[i*16 +: 16] = {ctl_reg[15:5], ovf_reg, not_empty,
                                        ctl_reg[2:0]};
      assign ch_head_flat[i*16 +: 16] = not_empty ? mem_reg[rp_reg] : 16'h0000;
      assign ch_irq[i] = irq_reg;
      assign ch_wake[i] = wake_reg;
    end
  endgenerate

  // read mux; unmapped offsets answer with zero
  reg [15:0] rd_data;
  integer k;
  always @*
  begin
    rd_data = 16'h0000;
    case (wb_adr_i)
      `TPC_OFS_LO_CTL: rd_data = lo_ctl_reg;
      `TPC_OFS_HI_CTL: rd_data = hi_ctl_reg;
      `TPC_OFS_LO_CNT: rd_data = lo_cnt_reg;
      `TPC_OFS_HI_CNT: rd_data = hi_cnt_reg;
      default: rd_data = 16'h0000;
    endcase
    for (k = 0; k < NCH; k = k + 1)
    begin
      if (wb_adr_i == `TPC_OFS_CH_BASE + k[7:0] * `TPC_OFS_CH_STEP)
        rd_data = ch_ctl_flat[k*16 +: 16];
      if (wb_adr_i == `TPC_OFS_CH_BASE + k[7:0] * `TPC_OFS_CH_STEP + `TPC_OFS_CH_BUF)
        rd_data = ch_head_flat[k*16 +: 16];
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      capture_irq <= {NCH{1'b0}};
      wake_req <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req;
      if (rd)
        wb_dat_o <= {16'h0000, rd_data};
      capture_irq <= ch_irq;
      wake_req <= |ch_wake;
    end
  end

endmodule // tpc_top

// ### tb/test_timer_pair_input_capture.sv
// self-checking bench for the timer pair and capture block
module test_timer_pair_input_capture;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] md; logic [1:0] ic; logic [4:0] np; logic [2:0] pu;
    logic [2:0] iq;} tpc_row_t;
  tpc_row_t rows [8] = '{'{3'h3, 2'h0, 5'h03, 3'h3, 3'h3}, '{3'h2, 2'h0, 5'h03, 3'h3, 3'h3},
    '{3'h1, 2'h3, 5'h02, 3'h4, 3'h4}, '{3'h3, 2'h1, 5'h04, 3'h4, 3'h2},
    '{3'h4, 2'h0, 5'h08, 3'h2, 3'h2}, '{3'h5, 2'h0, 5'h10, 3'h1, 3'h1},
    '{3'h6, 2'h0, 5'h03, 3'h0, 3'h0}, '{3'h0, 2'h0, 5'h03, 3'h0, 3'h0}};
  logic sys_clk, rst, cyc, stb, we, idle, sleep, ack, lo_w, hi_w, wake;
  logic [7:0] adr;
  logic [31:0] dat, rdat;
  logic [1:0] cirq;
  logic [3:0] pins;
  logic [15:0] q, prev;
  int bad_count, checked, nirq, nirq1, nwake, nlo, nhi, n, m;
  tpc_top u_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cpu_idle(idle), .cpu_sleep(sleep), .external_counter_clock_pin(pins[3:2]),
    .capture_pin(pins[1:0]), .lo_wrap_irq(lo_w), .hi_wrap_irq(hi_w), .capture_irq(cirq),
    .wake_req(wake));
  tpc_pin_model u_pins (.sys_clk(sys_clk), .pins(pins));
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    nirq <= nirq + cirq[0];
    nirq1 <= nirq1 + cirq[1];
    nwake <= nwake + wake;
    nlo <= nlo + lo_w;
    nhi <= nhi + hi_w;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one classic cycle; the request stays up until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0000, d};
    do
    begin
      @(posedge sys_clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1)
    begin
      bad_count++;
      test_done();
    end
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, idle, sleep, adr, dat} = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4)
    begin
      wb(0, a[7:0], 16'h0000);
      chk(q, 16'h0000);
    end
    wb(1, 8'hf0, 16'hffff);
    wb(0, 8'hf0, 16'h0000);
    chk(q, 16'h0000);
    wb(1, 8'h00, 16'h8000);
    foreach (rows[i])
    begin
      wb(1, 8'h10, {8'h00, 1'b1, rows[i].ic, 2'h0, rows[i].md});
      n = nirq;
      u_pins.pulses(0, rows[i].np);
      repeat (8) @(posedge sys_clk);
      chk(nirq - n, rows[i].iq);
      wb(0, 8'h10, 16'h0000);
      chk(q[3], rows[i].pu != 0);
      prev = 16'h0000;
      for (int k = 0; k < rows[i].pu; k++)
      begin
        wb(0, 8'h14, 16'h0000);
        chk(q > prev, 1);
        prev = q;
      end
      wb(0, 8'h10, 16'h0000);
      chk(q[4:3], 2'h0);
    end
    wb(1, 8'h0c, 16'h1234);
    wb(1, 8'h18, 16'h0003);
    m = nirq1;
    u_pins.pulses(1, 1);
    repeat (8) @(posedge sys_clk);
    wb(0, 8'h1c, 16'h0000);
    chk(q, 16'h1234);
    chk(nirq1 - m, 1);
    wb(1, 8'h10, 16'h0083);
    u_pins.pulses(0, 5);
    wb(0, 8'h10, 16'h0000);
    chk(q[4:3], 2'h3);
    repeat (4) wb(0, 8'h14, 16'h0000);
    wb(0, 8'h10, 16'h0000);
    chk(q[4:3], 2'h0);
    idle <= 1'b1;
    wb(1, 8'h10, 16'h0007);
    n = nwake;
    u_pins.pulses(0, 1);
    repeat (8) @(posedge sys_clk);
    chk(nwake - n, 1);
    idle <= 1'b0;
    sleep <= 1'b1;
    n = nwake;
    u_pins.pulses(0, 1);
    repeat (8) @(posedge sys_clk);
    chk(nwake - n, 1);
    sleep <= 1'b0;
    n = nwake;
    u_pins.pulses(0, 1);
    repeat (8) @(posedge sys_clk);
    chk(nwake - n, 0);
    idle <= 1'b1;
    wb(1, 8'h10, 16'h2083);
    n = nwake;
    u_pins.pulses(0, 1);
    repeat (8) @(posedge sys_clk);
    wb(0, 8'h10, 16'h0000);
    chk(nwake - n, 0);
    chk(q[3], 1'b0);
    idle <= 1'b0;
    wb(1, 8'h00, 16'h0000);
    wb(1, 8'h08, 16'h0000);
    wb(1, 8'h00, 16'h8042);
    u_pins.pulses(2, 5);
    wb(1, 8'h00, 16'h0000);
    wb(0, 8'h08, 16'h0000);
    chk(q, 16'h0005);
    wb(1, 8'h08, 16'h0000);
    wb(1, 8'h00, 16'h8010);
    repeat (80) @(posedge sys_clk);
    wb(1, 8'h00, 16'h0000);
    wb(0, 8'h08, 16'h0000);
    chk(q >= 16'h0009 && q <= 16'h000b, 1);
    for (int j = 0; j < 2; j++)
    begin
      wb(1, 8'h08, 16'hfff0);
      wb(1, 8'h0c, 16'hffff);
      n = nlo;
      m = nhi;
      wb(1, 8'h00, j ? 16'h8008 : 16'h8000);
      repeat (40) @(posedge sys_clk);
      wb(1, 8'h00, 16'h0000);
      chk(nlo - n, 1 - j);
      chk(nhi - m, j);
      wb(0, 8'h0c, 16'h0000);
      chk(q, j ? 16'h0000 : 16'hffff);
    end
    // gated accumulation: two pulses of four high cycles each
    wb(1, 8'h08, 16'h0000);
    wb(1, 8'h00, 16'h8040);
    u_pins.pulses(2, 2);
    wb(1, 8'h00, 16'h0000);
    wb(0, 8'h08, 16'h0000);
    chk(q, 16'h0008);
    wb(1, 8'h0c, 16'h0000);
    wb(1, 8'h04, 16'h8020);
    repeat (200) @(posedge sys_clk);
    wb(1, 8'h04, 16'h0000);
    wb(0, 8'h0c, 16'h0000);
    chk(q, 16'h0003);
    wb(1, 8'h0c, 16'h0000);
    idle <= 1'b1;
    wb(1, 8'h04, 16'ha000);
    repeat (20) @(posedge sys_clk);
    wb(1, 8'h04, 16'h0000);
    idle <= 1'b0;
    wb(0, 8'h0c, 16'h0000);
    chk(q, 16'h0000);
    // joined with the lower timer stopped: upper run bit must do nothing
    wb(1, 8'h00, 16'h0008);
    wb(1, 8'h04, 16'h8000);
    repeat (20) @(posedge sys_clk);
    wb(0, 8'h0c, 16'h0000);
    chk(q, 16'h0000);
    test_done();
  end
endmodule // test_timer_pair_input_capture
bind tpc_top tpc_top_sva #(.NCH(NCH)) u_sva (.sys_clk(sys_clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
  .external_counter_clock_pin(external_counter_clock_pin), .capture_pin(capture_pin),
  .lo_wrap_irq(lo_wrap_irq), .hi_wrap_irq(hi_wrap_irq), .capture_irq(capture_irq),
  .wake_req(wake_req));

// ### tb/tpc_pin_model.sv
// capture and counter clock pins driven toward the block
module tpc_pin_model (
  input wire logic sys_clk,
  output logic [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = 4'h0;
  // four cycles per level so the two-stage synchroniser never misses one
  task automatic pulses(input int sel, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      pins[sel] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      pins[sel] <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule // tpc_pin_model

// ### tb/tpc_top_sva.sv
// port-level assertions for the timer pair and capture block
module tpc_top_sva #(
  parameter NCH = 2
) (
  input wire sys_clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire cpu_idle,
  input wire cpu_sleep,
  input wire [1:0] external_counter_clock_pin,
  input wire [NCH-1:0] capture_pin,
  input wire lo_wrap_irq,
  input wire hi_wrap_irq,
  input wire [NCH-1:0] capture_irq,
  input wire wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic prev_reg;
  logic [3:0] quiet_reg;
  // cycles since channel 0 pin last changed, saturating
  always_ff @(posedge sys_clk)
  begin
    prev_reg <= capture_pin[0];
    if (capture_pin[0] != prev_reg)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf)
      quiet_reg <= quiet_reg + 4'h1;
  end
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_upper_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !wb_ack_o && !wake_req &&
    capture_irq == '0 && !lo_wrap_irq && !hi_wrap_irq) else $error("output in reset");
  wake_cause_a: assert property ((!cpu_idle && !cpu_sleep)[*3] |=> !wake_req)
    else $error("wake while running");
  cirq_cause_a: assert property (capture_irq[0] |-> quiet_reg < 4'h8)
    else $error("irq without pin edge");
  lo_wrap_single_a: assert property (lo_wrap_irq |=> !lo_wrap_irq)
    else $error("wrap pulse too long");
  cover property (wake_req);
  cover property (capture_irq[0]);
  cover property (capture_irq[1]);
  cover property (hi_wrap_irq);
endmodule // tpc_top_sva
